/* rtl/two_wire_eeprom_slave.sv */
// Slave protocol engine of a 512-byte two-wire nonvolatile memory.
// Assumes the bus pins are asynchronous and far slower than CLK.
// What this block does
// R01: Data edge with clock high is start/stop
// R02: Select byte: code, address high bit, direction
// R03: Acknowledge holds data low on ninth clock
// R04: Not-acknowledge releases data on ninth clock
// R05: Start always resets protocol state
// R06: Accept up to sixteen write bytes
// R07: Write: select, address byte loads counter
// R08: Write bytes bump low four address bits
// R09: Extra write bytes wrap within page
// R10: Stop after write starts programming
// R11: No select acknowledge while programming
// R12: Reads return any number of bytes
// R13: Counter holds last address plus one
// R14: Current read sends counter byte, increments
// R15: Master ack continues, nack ends read
// R16: After top address, counter rolls over to 0x000
// R17: Selective read: address then reselect
// R18: Sequential read wraps past top address
// R19: Ignore transaction on wrong select code
`default_nettype none
`include "ee_slave_cfg.svh"

module two_wire_eeprom_slave (
   input  wire logic  CLK,
   input  wire logic  RESET,
   input  wire logic  SCL_I,
   input  wire logic  SDA_I,
   output logic       SDA_O,
   output logic       SDA_OE,
   output logic       PROG_BUSY
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_d;
   logic       sda_d;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], SCL_I};
         sda_sync <= {sda_sync[0], SDA_I};
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
      end
   end

   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   assign scl_rise   = scl_s & ~scl_d;
   assign scl_fall   = ~scl_s & scl_d;
   // R01 start stop detect
   assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ee_slave_pkg::state_t state;
   ee_slave_pkg::state_t next_state;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic        in_ack;
   logic        next_in_ack;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [7:0]  tx;
   logic [7:0]  next_tx;
   logic        drive_low;
   logic        next_drive_low;
   logic        dir_rd;
   logic        next_dir_rd;
   logic        master_ack;
   logic        next_master_ack;
   logic        addr_msb;
   logic        next_addr_msb;
   logic [7:0]  addr_cnt;
   logic [7:0]  next_addr_cnt;
   logic [7:0]  page_buf [0:`EE_PAGE_BYTES-1];
   logic [7:0]  next_page_buf [0:`EE_PAGE_BYTES-1];
   logic [`EE_PAGE_BYTES-1:0] page_mask;
   logic [`EE_PAGE_BYTES-1:0] next_page_mask;
   logic [4:0]  page_base;
   logic [4:0]  next_page_base;
   logic        busy;
   logic        next_busy;
   logic [4:0]  prog_idx;
   logic [4:0]  next_prog_idx;
   logic [11:0] prog_timer;
   logic [11:0] next_prog_timer;
   logic                  mem_wr_en;
   logic [`EE_ADDR_W-1:0] mem_wr_addr;
   logic [7:0]            mem_wr_data;
   logic [7:0]            mem_rd_data;
   logic [`EE_ADDR_W-1:0] full_addr;
   logic [`EE_ADDR_W-1:0] full_addr_inc;
   logic                  sel_match;
   assign full_addr     = {addr_msb, addr_cnt};
   assign full_addr_inc = full_addr + 9'h001;
   assign sel_match     = (shreg[`EE_SEL_HI:`EE_SEL_LO] == `EE_SEL_CODE);
   // Read port follows the counter, so data is ready long before a load
   ee_mem_array u_mem (
      .clk     (CLK),
      .wr_en   (mem_wr_en),
      .wr_addr (mem_wr_addr),
      .wr_data (mem_wr_data),
      .rd_addr (full_addr),
      .rd_data (mem_rd_data)
   );

   // ----------------------------------------------------------------
   // Next-value logic
   // ----------------------------------------------------------------
   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_in_ack     = in_ack;
      next_shreg      = shreg;
      next_tx         = tx;
      next_drive_low  = drive_low;
      next_dir_rd     = dir_rd;
      next_master_ack = master_ack;
      next_addr_msb   = addr_msb;
      next_addr_cnt   = addr_cnt;
      next_page_buf   = page_buf;
      next_page_mask  = page_mask;
      next_page_base  = page_base;
      next_busy       = busy;
      next_prog_idx   = prog_idx;
      next_prog_timer = prog_timer;
      mem_wr_en       = 1'b0;
      mem_wr_addr     = {page_base, prog_idx[3:0]};
      mem_wr_data     = page_buf[prog_idx[3:0]];
      // Programming: copy marked bytes, then hold busy for the cell time
      if (busy) begin
         if (!prog_idx[4]) begin
            mem_wr_en     = page_mask[prog_idx[3:0]];
            next_prog_idx = prog_idx + 5'h01;
         end else if (prog_timer != 12'h000) begin
            next_prog_timer = prog_timer - 12'h001;
         end else begin
            next_busy      = 1'b0;
            next_page_mask = '0;
         end
      end
      if (start_cond) begin
         // R05 start resets protocol
         next_state     = ee_slave_pkg::ST_SEL;
         next_bit_cnt   = 4'h0;
         next_in_ack    = 1'b0;
         next_drive_low = 1'b0;
         if (!busy) begin
            next_page_mask = '0;
         end
      end else if (stop_cond) begin
         next_state     = ee_slave_pkg::ST_IDLE;
         next_drive_low = 1'b0;
         // R10 stop starts programming
         if (state == ee_slave_pkg::ST_WR && page_mask != '0 && !busy) begin
            next_busy       = 1'b1;
            next_prog_idx   = 5'h00;
            next_prog_timer = 12'(`EE_PROG_CYCLES);
            next_page_base  = {addr_msb, addr_cnt[7:4]};
         end
      end else if (scl_rise && state != ee_slave_pkg::ST_IDLE) begin
         if (!in_ack) begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
         end else if (state == ee_slave_pkg::ST_RD) begin
            next_master_ack = ~sda_s;
         end
      end else if (scl_fall && state != ee_slave_pkg::ST_IDLE) begin
         if (!in_ack && bit_cnt == 4'h8) begin
            next_in_ack = 1'b1;
            unique case (state)
               ee_slave_pkg::ST_SEL: begin
                  // R11 R19 refuse when busy or foreign code
                  if (sel_match && !busy) begin
                     next_drive_low = 1'b1;
                     // R02 high address bit and direction
                     next_addr_msb  = shreg[`EE_SEL_MSB_BIT];
                     next_dir_rd    = shreg[`EE_SEL_DIR_BIT];
                  end else begin
                     next_drive_low = 1'b0;
                     next_state     = ee_slave_pkg::ST_IDLE;
                  end
               end
               ee_slave_pkg::ST_ADDR: begin
                  // R07 R17 load address counter
                  next_addr_cnt  = shreg;
                  next_drive_low = 1'b1;
               end
               ee_slave_pkg::ST_WR: begin
                  // R06 R08 R09 buffer byte, wrap in page
                  next_page_buf[addr_cnt[3:0]]  = shreg;
                  next_page_mask[addr_cnt[3:0]] = 1'b1;
                  next_addr_cnt  = {addr_cnt[7:4], addr_cnt[3:0] + 4'h1};
                  next_drive_low = 1'b1;
               end
               // Transmit byte done; master owns the slot
               default: next_drive_low = 1'b0;
            endcase
         end else if (in_ack) begin
            // R03 R04 acknowledge slot ends
            next_in_ack    = 1'b0;
            next_bit_cnt   = 4'h0;
            next_drive_low = 1'b0;
            unique case (state)
               ee_slave_pkg::ST_SEL: begin
                  if (dir_rd) begin
                     // R14 R16 R18 send counter byte, step 9 bits
                     next_state     = ee_slave_pkg::ST_RD;
                     next_tx        = mem_rd_data;
                     next_drive_low = ~mem_rd_data[7];
                     {next_addr_msb, next_addr_cnt} = full_addr_inc;
                  end else begin
                     next_state = ee_slave_pkg::ST_ADDR;
                  end
               end
               ee_slave_pkg::ST_ADDR, ee_slave_pkg::ST_WR: next_state = ee_slave_pkg::ST_WR;
               default: begin
                  // R12 R13 R15 continue on ack, release on nack
                  if (master_ack) begin
                     next_tx        = mem_rd_data;
                     next_drive_low = ~mem_rd_data[7];
                     {next_addr_msb, next_addr_cnt} = full_addr_inc;
                  end else begin
                     next_state = ee_slave_pkg::ST_IDLE;
                  end
               end
            endcase
         end else if (state == ee_slave_pkg::ST_RD) begin
            next_tx        = {tx[6:0], 1'b0};
            next_drive_low = ~tx[6];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state      <= ee_slave_pkg::ST_IDLE;
         bit_cnt    <= 4'h0;
         in_ack     <= 1'b0;
         shreg      <= 8'h00;
         tx         <= 8'h00;
         drive_low  <= 1'b0;
         dir_rd     <= 1'b0;
         master_ack <= 1'b0;
         addr_msb   <= 1'b0;
         addr_cnt   <= 8'h00;
         page_mask  <= '0;
         page_base  <= 5'h00;
         busy       <= 1'b0;
         prog_idx   <= 5'h00;
         prog_timer <= 12'h000;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         in_ack     <= next_in_ack;
         shreg      <= next_shreg;
         tx         <= next_tx;
         drive_low  <= next_drive_low;
         dir_rd     <= next_dir_rd;
         master_ack <= next_master_ack;
         addr_msb   <= next_addr_msb;
         addr_cnt   <= next_addr_cnt;
         page_mask  <= next_page_mask;
         page_base  <= next_page_base;
         busy       <= next_busy;
         prog_idx   <= next_prog_idx;
         prog_timer <= next_prog_timer;
         page_buf   <= next_page_buf;
      end
   end

   assign SDA_O     = 1'b0;
   assign SDA_OE    = drive_low;
   assign PROG_BUSY = busy;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // A clock fall excludes start and stop, which need the clock high
   chk_nack_when_busy: assert property (@(posedge CLK) disable iff (RESET) // R11
      (scl_fall && !in_ack && bit_cnt == 4'h8 && state == ee_slave_pkg::ST_SEL && busy)
      |=> (!SDA_OE && state == ee_slave_pkg::ST_IDLE)) else $error("select acked while busy");
   chk_foreign_code: assert property (@(posedge CLK) disable iff (RESET) // R19
      (scl_fall && !in_ack && bit_cnt == 4'h8 && state == ee_slave_pkg::ST_SEL && !sel_match)
      |=> (!SDA_OE && state == ee_slave_pkg::ST_IDLE)) else $error("foreign code acked");
   chk_addr_load: assert property (@(posedge CLK) disable iff (RESET) // R07
      (scl_fall && !in_ack && bit_cnt == 4'h8 && state == ee_slave_pkg::ST_ADDR)
      |=> (SDA_OE && addr_cnt == $past(shreg))) else $error("address byte not taken");
   chk_page_wrap: assert property (@(posedge CLK) disable iff (RESET) // R09
      (scl_fall && !in_ack && bit_cnt == 4'h8 && state == ee_slave_pkg::ST_WR)
      |=> (addr_cnt[7:4] == $past(addr_cnt[7:4]) && SDA_OE
           && addr_cnt[3:0] == $past(addr_cnt[3:0]) + 4'h1))
      else $error("write address step wrong");
   chk_stop_programs: assert property (@(posedge CLK) disable iff (RESET) // R10
      (stop_cond && state == ee_slave_pkg::ST_WR && page_mask != '0 && !busy)
      |=> busy ##1 (busy && prog_idx == 5'h01)) else $error("programming did not start");
   chk_start_resets: assert property (@(posedge CLK) disable iff (RESET) // R05
      start_cond |=> (state == ee_slave_pkg::ST_SEL && bit_cnt == 4'h0 && !SDA_OE && !in_ack))
      else $error("start did not reset protocol state");
   chk_read_step: assert property (@(posedge CLK) disable iff (RESET) // R14
      (scl_fall && in_ack && ((state == ee_slave_pkg::ST_SEL && dir_rd)
       || (state == ee_slave_pkg::ST_RD && master_ack)))
      |=> (full_addr == $past(full_addr_inc) && tx == $past(mem_rd_data)))
      else $error("read load or counter step wrong");
   chk_nack_release: assert property (@(posedge CLK) disable iff (RESET) // R15
      (scl_fall && in_ack && state == ee_slave_pkg::ST_RD && !master_ack)
      |=> (!SDA_OE && state == ee_slave_pkg::ST_IDLE)) else $error("bus held after nack");
   chk_edge_scl_low: assert property (@(posedge CLK) disable iff (RESET) // R01
      ($changed(SDA_OE) && !$past(start_cond) && !$past(stop_cond)) |-> !$past(scl_s))
      else $error("data driven change while clock high");

endmodule // two_wire_eeprom_slave

`default_nettype wire

/* rtl/ee_slave_cfg.svh */
// Constants for the two-wire nonvolatile memory slave.
// Assumes a 250 MHz core clock and a bus clock far slower than it.
`ifndef EE_SLAVE_CFG_SVH
`define EE_SLAVE_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define EE_ADDR_W      9
`define EE_DEPTH       512
`define EE_PAGE_BYTES  16

// ----------------------------------------------------------------
// Select byte layout
// ----------------------------------------------------------------
`define EE_SEL_CODE    6'h28
`define EE_SEL_HI      7
`define EE_SEL_LO      2
`define EE_SEL_MSB_BIT 1
`define EE_SEL_DIR_BIT 0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_CLK_PERIOD_NS 4
`define EE_PROG_TIME_NS  1000
`define EE_PROG_CYCLES   ((`EE_PROG_TIME_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)

`endif

/* rtl/ee_slave_pkg.sv */
// Types shared by the two-wire memory slave files.
// Assumes nothing of its surroundings.
`default_nettype none

package ee_slave_pkg;

   // ----------------------------------------------------------------
   // Protocol phases, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_SEL  = 5'h02,
      ST_ADDR = 5'h04,
      ST_WR   = 5'h08,
      ST_RD   = 5'h10
   } state_t;

endpackage : ee_slave_pkg

`default_nettype wire

/* rtl/ee_mem_array.sv */
// Byte array of the nonvolatile store, one write and one read port.
// Assumes one clock; read data appear one edge after the address.
`default_nettype none
`include "ee_slave_cfg.svh"

module ee_mem_array (
   input  wire logic                    clk,
   input  wire logic                    wr_en,
   input  wire logic [`EE_ADDR_W-1:0]   wr_addr,
   input  wire logic [7:0]              wr_data,
   input  wire logic [`EE_ADDR_W-1:0]   rd_addr,
   output logic      [7:0]              rd_data
);

   logic [7:0] store [0:`EE_DEPTH-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end

endmodule // ee_mem_array

`default_nettype wire

/* tb/ee_bus_master.sv */
// Behavioural two-wire bus master driving the memory slave.
// Assumes calls begin just after a falling CLK edge; data has a pull-up.
`default_nettype none

module ee_bus_master (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;

   // Clock stands high between frames
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // ----------------------------------------------------------------
   // Bit level
   // ----------------------------------------------------------------
   // data moves clock low
   task automatic put_bit(input logic b);
      sda_low = ~b;
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
   endtask

   task automatic get_bit(output logic b);
      sda_low = 1'b0;
      #20 scl = 1'b1;
      #20 b = sda;
      #20 scl = 1'b0;
      #20;
   endtask

   task automatic start();
      sda_low = 1'b0;
      #20 scl = 1'b1;
      #20 sda_low = 1'b1;
      #20 scl = 1'b0;
      #20;
   endtask

   task automatic stop();
      sda_low = 1'b1;
      #20 scl = 1'b1;
      #20 sda_low = 1'b0;
      #20;
   endtask

   // ----------------------------------------------------------------
   // Byte level
   // ----------------------------------------------------------------
   // slot nine
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i]);
      end
      get_bit(b);
      ack = ~b;
   endtask

   task automatic rd_byte(input logic more, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(~more);
   endtask

   task automatic recover(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 9 && !ok; i++) begin
         sda_low = 1'b0;
         #20 scl = 1'b1;
         #20 ok = sda;
         if (ok) begin
            sda_low = 1'b1;
         end
         #20 scl = 1'b0;
         #20;
      end
   endtask

endmodule // ee_bus_master

`default_nettype wire

/* tb/tb_two_wire_eeprom_slave.sv */
// Self-checking bench for the two-wire memory slave.
// Assumes the bus master model and the slave sources are compiled first.
`default_nettype none
`include "ee_slave_cfg.svh"

module tb_two_wire_eeprom_slave;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] data;
   } row_t;

   logic       clk;
   logic       reset;
   logic       scl;
   logic       sda_low;
   logic       sda;
   logic       sda_o;
   logic       sda_oe;
   logic       prog_busy;
   logic       ack;
   logic       ok;
   int         fail_count = 0;
   int         num_checks = 0;
   logic [7:0] mem_exp [0:511];
   // Last row at the top address so the counter wraps for the current read
   row_t       rows [5] = '{'{9'h000, 8'h5a}, '{9'h0ff, 8'ha5}, '{9'h100, 8'h3c},
                            '{9'h0a5, 8'h81}, '{9'h1ff, 8'hc3}};

   // Open drain with pull-up
   assign sda = ~sda_low & (sda_oe ? sda_o : 1'b1);

   two_wire_eeprom_slave u_two_wire_eeprom_slave (
      .CLK       (clk),
      .RESET     (reset),
      .SCL_I     (scl),
      .SDA_I     (sda),
      .SDA_O     (sda_o),
      .SDA_OE    (sda_oe),
      .PROG_BUSY (prog_busy)
   );

   ee_bus_master u_ee_bus_master (
      .scl     (scl),
      .sda_low (sda_low),
      .sda     (sda)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk_bit(input string name, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask

   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Transactions
   // ----------------------------------------------------------------
   task automatic sel(input logic hi, input logic dir, output logic a);
      u_ee_bus_master.start();
      u_ee_bus_master.wr_byte({`EE_SEL_CODE, hi, dir}, a);
   endtask

   // Page wrap mirrored in the expected image
   task automatic write_bytes(input logic [8:0] a, input int n, input logic [7:0] d0);
      logic [3:0] slot;
      logic       busy_seen;
      logic       a2;
      busy_seen = 1'b0;
      sel(a[8], 1'b0, a2);
      chk_bit("select ack", 1'b1, a2);
      u_ee_bus_master.wr_byte(a[7:0], a2);
      chk_bit("address ack", 1'b1, a2);
      for (int k = 0; k < n; k++) begin
         slot = a[3:0] + k[3:0];
         mem_exp[{a[8:4], slot}] = d0 + k[7:0];
         u_ee_bus_master.wr_byte(d0 + k[7:0], a2);
         chk_bit("data ack", 1'b1, a2);
      end
      u_ee_bus_master.stop();
      for (int i = 0; i < 10 && !busy_seen; i++) begin
         @(negedge clk);
         busy_seen = (prog_busy === 1'b1);
      end
      chk_bit("prog_busy", 1'b1, busy_seen);
      for (int i = 0; i < 20; i++) begin
         sel(a[8], 1'b0, a2);
         u_ee_bus_master.stop();
         if (i == 0) begin
            chk_bit("poll ack busy", 1'b0, a2);
         end
         if (a2) begin
            return;
         end
      end
      fail_count++;
      stop_test();
   endtask

   task automatic read_bytes(input logic with_addr, input logic [8:0] a, input int n);
      logic [7:0] d;
      logic       a2;
      if (with_addr) begin
         sel(a[8], 1'b0, a2);
         chk_bit("select ack", 1'b1, a2);
         u_ee_bus_master.wr_byte(a[7:0], a2);
         chk_bit("address ack", 1'b1, a2);
      end
      sel(a[8], 1'b1, a2);
      chk_bit("read select ack", 1'b1, a2);
      for (int k = 0; k < n; k++) begin
         u_ee_bus_master.rd_byte(k < n - 1, d);
         chk_byte("read data", mem_exp[a + k[8:0]], d);
      end
      u_ee_bus_master.stop();
      chk_bit("released", 1'b0, sda_oe);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      chk_bit("sda_oe reset", 1'b0, sda_oe);
      chk_bit("prog_busy reset", 1'b0, prog_busy);
      repeat (4) @(negedge clk);
      foreach (rows[i]) begin
         write_bytes(rows[i].addr, 1, rows[i].data);
         read_bytes(1'b1, rows[i].addr, 1);
      end
      read_bytes(1'b0, 9'h000, 1);
      write_bytes(9'h03e, 18, 8'h80);
      read_bytes(1'b1, 9'h030, 16);
      read_bytes(1'b1, 9'h1ff, 2);
      u_ee_bus_master.start();
      u_ee_bus_master.wr_byte({`EE_SEL_CODE ^ 6'h01, 1'b0, 1'b0}, ack);
      chk_bit("foreign select ack", 1'b0, ack);
      u_ee_bus_master.wr_byte(8'h00, ack);
      chk_bit("ignored byte ack", 1'b0, ack);
      u_ee_bus_master.stop();
      // Abort a read of a known byte (0x81) mid-byte; its zeros make recovery clock
      sel(1'b0, 1'b0, ack);
      u_ee_bus_master.wr_byte(8'ha5, ack);
      sel(1'b0, 1'b1, ack);
      chk_bit("abort read ack", 1'b1, ack);
      repeat (3) u_ee_bus_master.get_bit(ok);
      u_ee_bus_master.recover(ok);
      chk_bit("recovered", 1'b1, ok);
      u_ee_bus_master.wr_byte({`EE_SEL_CODE, 1'b0, 1'b0}, ack);
      chk_bit("select after recovery", 1'b1, ack);
      u_ee_bus_master.stop();
      // Reset in mid-programming must drop busy and free the bus
      sel(1'b0, 1'b0, ack);
      u_ee_bus_master.wr_byte(8'h10, ack);
      u_ee_bus_master.wr_byte(8'h77, ack);
      u_ee_bus_master.stop();
      repeat (4) @(negedge clk);
      chk_bit("busy before reset", 1'b1, prog_busy);
      reset = 1'b1;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      chk_bit("busy after reset", 1'b0, prog_busy);
      chk_bit("sda_oe after reset", 1'b0, sda_oe);
      repeat (4) @(negedge clk);
      sel(1'b0, 1'b0, ack);
      chk_bit("select after reset", 1'b1, ack);
      u_ee_bus_master.stop();
      repeat (10) @(negedge clk);
      stop_test();
   end

endmodule // tb_two_wire_eeprom_slave

`default_nettype wire
